// >>> core/char_fifo.sv
`timescale 1ns/1ps
module char_fifo (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic single_i,
  input wire logic push_i,
  input wire logic [7:0] push_data_i,
  input wire logic pop_i,
  output logic [7:0] head_o,
  output logic empty_o,
  output logic full_o,
  output logic lost_o,
  output logic replaced_o,
  output logic [4:0] count_o
);

  logic [7:0] mem_q [shadow_pkg::FIFO_DEPTH];
  logic [3:0] rd_ptr_q;
  logic [3:0] wr_ptr_q;
  logic [4:0] count_q;
  logic do_pop;
  logic do_push;

  // ==========================================================================
  // Occupancy; single mode holds one character and overwrites it
  assign empty_o = (count_q == 5'h00);
  assign full_o = single_i ? !empty_o : (count_q == 5'(shadow_pkg::FIFO_DEPTH));
  assign do_pop = pop_i && !empty_o;
  assign do_push = push_i && (!full_o || do_pop);
  assign replaced_o = push_i && full_o && !do_pop && single_i;
  assign lost_o = push_i && full_o && !do_pop && !single_i;
  assign head_o = mem_q[rd_ptr_q];
  assign count_o = count_q;

  // Storage, a replace rewrites the newest entry
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < shadow_pkg::FIFO_DEPTH; i++) begin
        mem_q[i] <= shadow_pkg::CHAR_RST;
      end
    end else if (do_push) begin
      mem_q[wr_ptr_q] <= push_data_i;
    end else if (replaced_o) begin
      mem_q[wr_ptr_q - 4'h1] <= push_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ptr_q <= 4'h0;
      wr_ptr_q <= 4'h0;
      count_q <= 5'h00;
    end else if (flush_i) begin
      rd_ptr_q <= wr_ptr_q;
      count_q <= 5'h00;
    end else begin
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      count_q <= count_q + {4'h0, do_push} - {4'h0, do_pop};
    end
  end

endmodule

// >>> core/shadow_data_port.sv
`timescale 1ns/1ps
// What this block does
// - sixteen consecutive word slots all alias receive buffer and transmit holding register
// - slot read returns in bits 7:0 the byte from serial or infrared input
// - read data are valid only while the receive ready flag is set
// - FIFOs off, a new character replaces an unread byte and flags overrun
// - FIFOs on, a slot read returns the oldest receive entry and pops it
// - receive FIFO full, new character is dropped, contents kept, overrun flagged
// - slot write queues a byte for serial or infrared transmit output
// - FIFOs off, a further write overwrites the pending transmit byte
// - FIFOs on, sixteen characters are accepted before full is reported
// - write while transmit FIFO is full is discarded, queue untouched
module shadow_data_port (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire shadow_pkg::bus_req_t bus_i,
  output logic [31:0] rdata_o,
  input wire shadow_pkg::char_t rx_uart_i,
  input wire shadow_pkg::char_t rx_ir_i,
  input wire logic tx_take_i,
  output shadow_pkg::char_t tx_uart_o,
  output shadow_pkg::char_t tx_ir_o,
  output logic irq_o
);

  // ==========================================================================
  // Address decode
  function automatic logic is_slot(input logic [31:0] a);
    return (a >= shadow_pkg::SLOT_BASE_ADDR) && (a <= shadow_pkg::SLOT_LAST_ADDR) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic hit(input shadow_pkg::bus_req_t b, input logic [31:0] a);
    return b.addr == a;
  endfunction

  logic [1:0] fc_q;
  logic [3:0] int_q;
  logic [3:0] mask_q;
  logic overrun_q;
  logic tx_empty_prev_q;
  logic [31:0] rdata_q;
  logic irq_q;
  shadow_pkg::char_t tx_uart_q;
  shadow_pkg::char_t tx_ir_q;

  logic fifo_en;
  logic ir_mode;
  logic slot_rd;
  logic slot_wr;
  logic fc_wr;
  logic flush;
  shadow_pkg::char_t rx_in;
  logic [7:0] rx_head;
  logic rx_empty;
  logic rx_full;
  logic rx_lost;
  logic rx_replaced;
  logic [4:0] rx_count;
  logic [7:0] tx_head;
  logic tx_empty;
  logic tx_full;
  logic tx_lost;
  logic tx_replaced;
  logic [4:0] tx_count;
  logic tx_load;
  logic out_valid;
  logic [31:0] line_status;
  logic [3:0] int_events;

  // ==========================================================================
  // Strobes and mode
  assign fifo_en = fc_q[shadow_pkg::FC_FIFO_EN];
  assign ir_mode = fc_q[shadow_pkg::FC_IR_MODE];
  assign slot_rd = bus_i.rd && is_slot(bus_i.addr);
  assign slot_wr = bus_i.wr && is_slot(bus_i.addr);
  assign fc_wr = bus_i.wr && hit(bus_i, shadow_pkg::FIFO_CTRL_ADDR);
  // Switching FIFO mode empties both queues
  assign flush = fc_wr && (bus_i.wdata[shadow_pkg::FC_FIFO_EN] != fifo_en);

  // Receive source follows the line mode
  assign rx_in = ir_mode ? rx_ir_i : rx_uart_i;

  // ==========================================================================
  // Receive queue
  char_fifo rx_fifo (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .single_i(!fifo_en),
    .push_i(rx_in.valid),
    .push_data_i(rx_in.data),
    .pop_i(slot_rd),
    .head_o(rx_head),
    .empty_o(rx_empty),
    .full_o(rx_full),
    .lost_o(rx_lost),
    .replaced_o(rx_replaced),
    .count_o(rx_count)
  );

  // ==========================================================================
  // Transmit queue
  char_fifo tx_fifo (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .single_i(!fifo_en),
    .push_i(slot_wr),
    .push_data_i(bus_i.wdata[7:0]),
    .pop_i(tx_load),
    .head_o(tx_head),
    .empty_o(tx_empty),
    .full_o(tx_full),
    .lost_o(tx_lost),
    .replaced_o(tx_replaced),
    .count_o(tx_count)
  );

  // ==========================================================================
  // Transmit presentation stage
  assign out_valid = tx_uart_q.valid || tx_ir_q.valid;
  assign tx_load = !tx_empty && (!out_valid || tx_take_i);

  // Head of queue goes to the output of the active mode
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_uart_q <= '0;
      tx_ir_q <= '0;
    end else if (tx_load) begin
      tx_uart_q <= '{valid: !ir_mode, data: tx_head};
      tx_ir_q <= '{valid: ir_mode, data: tx_head};
    end else if (tx_take_i) begin
      tx_uart_q.valid <= 1'b0;
      tx_ir_q.valid <= 1'b0;
    end
  end

  // ==========================================================================
  // Line status view
  always_comb begin
    line_status = 32'h0000_0000;
    line_status[shadow_pkg::LS_RX_READY] = !rx_empty;
    line_status[shadow_pkg::LS_OVERRUN] = overrun_q;
    line_status[shadow_pkg::LS_TX_EMPTY] = tx_empty;
    line_status[shadow_pkg::LS_TX_IDLE] = tx_empty && !out_valid;
  end

  // Overrun is sticky until line status is read; a new overrun wins
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overrun_q <= 1'b0;
    end else if (rx_lost || rx_replaced) begin
      overrun_q <= 1'b1;
    end else if (bus_i.rd && hit(bus_i, shadow_pkg::LINE_STATUS_ADDR)) begin
      overrun_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fc_q <= shadow_pkg::FIFO_CTRL_RST;
    end else if (fc_wr) begin
      fc_q <= bus_i.wdata[1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= shadow_pkg::INT_MASK_RST;
    end else if (bus_i.wr && hit(bus_i, shadow_pkg::INT_MASK_ADDR)) begin
      mask_q <= bus_i.wdata[3:0];
    end
  end

  // ==========================================================================
  // Interrupt status, cleared by read, events win over the clear
  always_comb begin
    int_events = 4'h0;
    int_events[shadow_pkg::INT_RX] = rx_in.valid;
    int_events[shadow_pkg::INT_OVERRUN] = rx_lost || rx_replaced;
    int_events[shadow_pkg::INT_TX_EMPTY] = tx_empty && !tx_empty_prev_q;
    int_events[shadow_pkg::INT_TX_LOST] = tx_lost;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_empty_prev_q <= 1'b1;
    end else begin
      tx_empty_prev_q <= tx_empty;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_q <= 4'h0;
    end else if (bus_i.rd && hit(bus_i, shadow_pkg::INT_STATUS_ADDR)) begin
      int_q <= int_events;
    end else begin
      int_q <= int_q | int_events;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_q & mask_q);
    end
  end

  // ==========================================================================
  // Read data, present for one cycle only, zero when unmapped
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (!bus_i.rd) begin
      rdata_q <= 32'h0000_0000;
    end else if (is_slot(bus_i.addr)) begin
      rdata_q <= {24'h00_0000, rx_head};
    end else begin
      case (bus_i.addr)
        shadow_pkg::FIFO_CTRL_ADDR: rdata_q <= {30'h0000_0000, fc_q};
        shadow_pkg::LINE_STATUS_ADDR: rdata_q <= line_status;
        shadow_pkg::INT_STATUS_ADDR: rdata_q <= {28'h000_0000, int_q};
        shadow_pkg::INT_MASK_ADDR: rdata_q <= {28'h000_0000, mask_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign rdata_o = rdata_q;
  assign tx_uart_o = tx_uart_q;
  assign tx_ir_o = tx_ir_q;
  assign irq_o = irq_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Steps shared by the guarded behaviours
  sequence rx_fresh_read_s;
    slot_rd && !rx_empty && !rx_in.valid && !flush;
  endsequence

  sequence tx_full_write_s;
    slot_wr && tx_full && !tx_load && !flush;
  endsequence

  sequence rx_full_arrival_s;
    rx_in.valid && rx_full && !slot_rd && !flush;
  endsequence

  reserved_bits_zero_a: assert property (
    slot_rd |=> rdata_q[31:8] == 24'h00_0000)
    else $error("slot read shows nonzero upper bits");

  rx_read_head_a: assert property (
    slot_rd && !rx_empty |=> rdata_q[7:0] == $past(rx_head))
    else $error("slot read does not return queue head");

  rx_read_pop_a: assert property (
    (fifo_en and rx_fresh_read_s) |=> rx_count == $past(rx_count) - 5'h01)
    else $error("slot read did not pop receive queue");

  rx_full_drop_a: assert property (
    (fifo_en and rx_full_arrival_s) |=> overrun_q && rx_count == $past(rx_count) && rx_head == $past(rx_head))
    else $error("full receive queue changed or no overrun");

  rx_replace_a: assert property (
    (!fifo_en and rx_full_arrival_s) ##1 !slot_rd |-> overrun_q && rx_head == $past(rx_in.data, 1))
    else $error("unread byte not replaced with overrun");

  tx_overwrite_a: assert property (
    (!fifo_en and tx_full_write_s) |=> tx_count == 5'h01 && tx_head == $past(bus_i.wdata[7:0]))
    else $error("pending transmit byte not overwritten");

  tx_full_discard_a: assert property (
    (fifo_en and tx_full_write_s) |=> tx_count == 5'(shadow_pkg::FIFO_DEPTH) && tx_head == $past(tx_head))
    else $error("write to full transmit queue disturbed it");

  tx_depth_a: assert property (
    fifo_en |-> tx_full == (tx_count == 5'(shadow_pkg::FIFO_DEPTH)))
    else $error("transmit full not at sixteen characters");

  tx_present_a: assert property (
    tx_load |=> ($past(ir_mode) ? tx_ir_q.valid && !tx_uart_q.valid : tx_uart_q.valid && !tx_ir_q.valid)
      && out_valid && ($past(ir_mode) ? tx_ir_q.data : tx_uart_q.data) == $past(tx_head))
    else $error("transmit byte not presented on active output");

  ready_flag_a: assert property (
    bus_i.rd && hit(bus_i, shadow_pkg::LINE_STATUS_ADDR) |=> rdata_q[0] == $past(!rx_empty)
      && rdata_q[5] == $past(tx_empty))
    else $error("line status flags do not match queues");

  irq_level_a: assert property (
    |(int_q & mask_q) |=> irq_q)
    else $error("interrupt not raised for unmasked status");

  // ==========================================================================
  // Bookkeeping of flags, modes and read data
  overrun_set_a: assert property (
    rx_lost || rx_replaced |=> overrun_q)
    else $error("overrun flag missed a lost character");

  int_rx_set_a: assert property (
    rx_in.valid |=> int_q[shadow_pkg::INT_RX])
    else $error("receive event not kept in interrupt status");

  irq_quiet_a: assert property (
    !(|(int_q & mask_q)) |=> !irq_q)
    else $error("interrupt raised without unmasked status");

  rx_single_a: assert property (
    !fifo_en |-> rx_count <= 5'h01)
    else $error("receive holding exceeds one byte with queues off");

  tx_single_a: assert property (
    !fifo_en |-> tx_count <= 5'h01)
    else $error("transmit holding exceeds one byte with queues off");

  rdata_idle_a: assert property (
    !bus_i.rd |=> rdata_q == 32'h0000_0000)
    else $error("read data not zero outside a read");

  tx_take_clear_a: assert property (
    tx_take_i && !tx_load |=> !out_valid)
    else $error("taken transmit byte still presented");

  flush_empty_a: assert property (
    flush |=> rx_empty && tx_empty)
    else $error("mode change did not empty both queues");

  tx_lost_flag_a: assert property (
    tx_lost |=> int_q[shadow_pkg::INT_TX_LOST] && tx_count == $past(tx_count))
    else $error("lost transmit write not flagged");

endmodule

// >>> core/shadow_pkg.sv
package shadow_pkg;

  // ==========================================================================
  // Widths and depths
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned INT_W = 4;

  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] SLOT_BASE_ADDR = 32'h5000_1030;
  localparam logic [31:0] SLOT_LAST_ADDR = 32'h5000_106C;
  localparam logic [31:0] SLOT4_ADDR = 32'h5000_1040;
  localparam logic [31:0] SLOT5_ADDR = 32'h5000_1044;
  localparam logic [31:0] FIFO_CTRL_ADDR = 32'h5000_1080;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1084;
  localparam logic [31:0] INT_STATUS_ADDR = 32'h5000_1088;
  localparam logic [31:0] INT_MASK_ADDR = 32'h5000_108C;

  // ==========================================================================
  // Field positions
  localparam int unsigned FC_FIFO_EN = 0;
  localparam int unsigned FC_IR_MODE = 1;
  localparam int unsigned LS_RX_READY = 0;
  localparam int unsigned LS_OVERRUN = 1;
  localparam int unsigned LS_TX_EMPTY = 5;
  localparam int unsigned LS_TX_IDLE = 6;
  localparam int unsigned INT_RX = 0;
  localparam int unsigned INT_OVERRUN = 1;
  localparam int unsigned INT_TX_EMPTY = 2;
  localparam int unsigned INT_TX_LOST = 3;

  // ==========================================================================
  // Reset values
  localparam logic [1:0] FIFO_CTRL_RST = 2'h0;
  localparam logic [3:0] INT_MASK_RST = 4'h0;
  localparam logic [7:0] CHAR_RST = 8'h00;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } char_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

endpackage

// >>> verif/line_model.sv
`timescale 1ns/1ps
// ====================
// Far side model: deframers and serialiser
module line_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire shadow_pkg::char_t send_i,
  input wire logic ir_i,
  input wire logic stall_i,
  input wire shadow_pkg::char_t tx_uart_i,
  input wire shadow_pkg::char_t tx_ir_i,
  output shadow_pkg::char_t rx_uart_o,
  output shadow_pkg::char_t rx_ir_o,
  output logic tx_take_o
);
  logic [7:0] last_q;
  // Remember the last byte so idle lines show its inverse
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_q <= 8'h00;
    end else if (send_i.valid) begin
      last_q <= send_i.data;
    end
  end
  // Deliver on the selected input only
  always_comb begin
    rx_uart_o = '{1'b0, ~last_q};
    rx_ir_o = rx_uart_o;
    if (send_i.valid && !ir_i) begin
      rx_uart_o = send_i;
    end
    if (send_i.valid && ir_i) begin
      rx_ir_o = send_i;
    end
  end
  // Take the presented character unless stalled
  assign tx_take_o = !stall_i && (ir_i ? tx_ir_i.valid : tx_uart_i.valid);
endmodule

// >>> verif/shadow_data_port_test.sv
`timescale 1ns/1ps
// ====================
// Bench for the shadow data slots
module shadow_data_port_test;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  shadow_pkg::bus_req_t bus = '0;
  shadow_pkg::char_t snd = '0;
  shadow_pkg::char_t rx_u, rx_i, tx_u, tx_i;
  logic [31:0] rdata;
  logic [31:0] d;
  logic take, irq;
  logic ir = 1'b0;
  logic stall = 1'b0;
  logic [7:0] txq[$];
  int error_cnt = 0;
  int checks_done = 0;

  shadow_data_port shadow_data_port_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
    .rx_uart_i(rx_u), .rx_ir_i(rx_i), .tx_take_i(take), .tx_uart_o(tx_u), .tx_ir_o(tx_i), .irq_o(irq));
  line_model line_model_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .send_i(snd), .ir_i(ir), .stall_i(stall),
    .tx_uart_i(tx_u), .tx_ir_i(tx_i), .rx_uart_o(rx_u), .rx_ir_o(rx_i), .tx_take_o(take));

  // 10 MHz clock
  always #50 ref_clk_i = ~ref_clk_i;

  // Collect every character the serialiser takes
  always @(posedge ref_clk_i) begin
    if (take === 1'b1) begin
      txq.push_back(ir ? tx_i.data : tx_u.data);
    end
  end

  // ====================
  // Shared tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge ref_clk_i);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata;
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    rd(a);
    chk(what, e, d & m);
  endtask
  task automatic send(input logic [7:0] c);
    @(posedge ref_clk_i);
    snd <= '{1'b1, c};
    @(posedge ref_clk_i);
    snd.valid <= 1'b0;
  endtask
  task automatic present();
    for (int i = 0; i < 10 && tx_u.valid !== 1'b1; i++) @(posedge ref_clk_i);
  endtask
  task automatic drain(input int n);
    for (int i = 0; i < 60 && txq.size() <= n; i++) @(posedge ref_clk_i);
    chk("tx count", n, txq.size());
  endtask

  // ====================
  // Scenarios
  task automatic t_reset();
    rc(shadow_pkg::SLOT4_ADDR, 32'hFFFF_FFFF, 32'h0000_0000, "slot4 reset");
    rc(shadow_pkg::SLOT5_ADDR, 32'hFFFF_FFFF, 32'h0000_0000, "slot5 reset");
    rc(shadow_pkg::LINE_STATUS_ADDR, 32'h0000_0063, 32'h0000_0060, "status reset");
    rc(32'h5000_1090, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_rx_off();
    send(8'h5A);
    rc(shadow_pkg::LINE_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001, "rx ready");
    rc(shadow_pkg::SLOT_BASE_ADDR, 32'hFFFF_FFFF, 32'h0000_005A, "slot0 byte");
    send(8'hC3);
    send(8'h3C);
    rc(shadow_pkg::LINE_STATUS_ADDR, 32'h0000_0003, 32'h0000_0003, "overrun off");
    rc(shadow_pkg::SLOT_LAST_ADDR, 32'hFFFF_FFFF, 32'h0000_003C, "replaced byte");
    rc(shadow_pkg::LINE_STATUS_ADDR, 32'h0000_0003, 32'h0000_0000, "status cleared");
    $display("test rx off done");
  endtask
  task automatic t_rx_fifo();
    wr(shadow_pkg::FIFO_CTRL_ADDR, 32'h0000_0001);
    for (int i = 0; i < 17; i++) send(8'h10 + 8'(i));
    rc(shadow_pkg::LINE_STATUS_ADDR, 32'h0000_0003, 32'h0000_0003, "overrun full");
    for (int i = 0; i < 16; i++) rc(shadow_pkg::SLOT_BASE_ADDR + 32'(4 * i), 32'hFFFF_FFFF, 32'h10 + 32'(i), "head");
    rc(shadow_pkg::LINE_STATUS_ADDR, 32'h0000_0001, 32'h0000_0000, "fifo empty");
    $display("test rx fifo done");
  endtask
  task automatic t_tx_off();
    wr(shadow_pkg::FIFO_CTRL_ADDR, 32'h0000_0000);
    stall <= 1'b1;
    txq.delete();
    rc(shadow_pkg::LINE_STATUS_ADDR, 32'h0000_0020, 32'h0000_0020, "tx empty");
    wr(shadow_pkg::SLOT4_ADDR, 32'h0000_AB21);
    present();
    wr(shadow_pkg::SLOT5_ADDR, 32'h0000_0022);
    wr(shadow_pkg::SLOT4_ADDR, 32'h0000_0023);
    stall <= 1'b0;
    drain(2);
    chk("first tx", 32'h0000_0021, txq[0]);
    chk("overwritten tx", 32'h0000_0023, txq[1]);
    $display("test tx off done");
  endtask
  task automatic t_tx_fifo();
    wr(shadow_pkg::FIFO_CTRL_ADDR, 32'h0000_0001);
    stall <= 1'b1;
    txq.delete();
    rd(shadow_pkg::INT_STATUS_ADDR);
    rc(shadow_pkg::LINE_STATUS_ADDR, 32'h0000_0020, 32'h0000_0020, "tx empty");
    wr(shadow_pkg::SLOT4_ADDR, 32'h0000_0040);
    present();
    for (int i = 1; i < 17; i++) wr(shadow_pkg::SLOT5_ADDR, 32'h40 + 32'(i));
    rc(shadow_pkg::LINE_STATUS_ADDR, 32'h0000_0020, 32'h0000_0000, "tx full");
    rc(shadow_pkg::INT_STATUS_ADDR, 32'h0000_0008, 32'h0000_0000, "no loss at depth");
    wr(shadow_pkg::SLOT4_ADDR, 32'h0000_007F);
    rc(shadow_pkg::INT_STATUS_ADDR, 32'h0000_0008, 32'h0000_0008, "tx lost");
    stall <= 1'b0;
    drain(17);
    for (int i = 0; i < 17; i++) chk("queued tx", 32'h40 + 32'(i), txq[i]);
    $display("test tx fifo done");
  endtask
  task automatic t_ir();
    wr(shadow_pkg::FIFO_CTRL_ADDR, 32'h0000_0002);
    ir <= 1'b1;
    txq.delete();
    send(8'h99);
    rc(shadow_pkg::SLOT5_ADDR, 32'hFFFF_FFFF, 32'h0000_0099, "ir byte");
    wr(shadow_pkg::SLOT4_ADDR, 32'h0000_0066);
    drain(1);
    chk("ir tx", 32'h0000_0066, txq[0]);
    wr(shadow_pkg::FIFO_CTRL_ADDR, 32'h0000_0000);
    ir <= 1'b0;
    $display("test ir done");
  endtask
  task automatic t_irq();
    rd(shadow_pkg::INT_STATUS_ADDR);
    wr(shadow_pkg::INT_MASK_ADDR, 32'h0000_0001);
    send(8'h11);
    repeat (3) @(posedge ref_clk_i);
    chk("irq raised", 32'h0000_0001, irq);
    rc(shadow_pkg::INT_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001, "rx event");
    rd(shadow_pkg::SLOT4_ADDR);
    repeat (2) @(posedge ref_clk_i);
    chk("irq cleared", 32'h0000_0000, irq);
    wr(shadow_pkg::INT_MASK_ADDR, 32'h0000_0000);
    send(8'h12);
    repeat (3) @(posedge ref_clk_i);
    chk("irq masked", 32'h0000_0000, irq);
    rc(shadow_pkg::INT_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001, "masked event");
    $display("test irq done");
  endtask

  // ====================
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_rx_off();
    t_rx_fifo();
    t_tx_off();
    t_tx_fifo();
    t_ir();
    t_irq();
    test_done();
  end

  // Watchdog against a hang
  initial begin
    #(100 * 20000);
    error_cnt++;
    test_done();
  end
endmodule
